//--- rtl/rps_pkg.sv
// Package of constants and types for the region protection block
package rps_pkg;

  // ****************************************************************
  // Register map (byte offsets chosen for the APB slave)
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_FETCH_BASE = 12'h100;
  localparam logic [11:0] OFS_FETCH_ATTR = 12'h140;
  localparam logic [11:0] OFS_DATA_BASE  = 12'h200;
  localparam logic [11:0] OFS_DATA_ATTR  = 12'h240;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int BIT_ENABLE     = 0;
  localparam int BIT_PROTECTION_CODE_LO    = 1;
  localparam int BIT_CACHEABLE  = 7;
  localparam int BIT_SPEC_LOAD_ZERO  = 8;
  localparam int BIT_SIZE_LO    = 12;
  localparam int BASE_LO        = 12;
  localparam logic [31:0] BASE_MASK       = 32'hFFFF_F000;
  localparam logic [31:0] DATA_ATTR_MASK  = 32'h0001_F187;
  localparam logic [31:0] FETCH_ATTR_MASK = 32'h0001_F007;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
  localparam logic [4:0]  SIZE_CODE_MIN   = 5'h0B;

  // Control register bits
  localparam int CTRL_FETCH_EN    = 0;
  localparam int CTRL_DATA_EN     = 1;
  localparam int CTRL_SPEC_FAULT  = 2;
  localparam int CTRL_SPEC_MALIGN = 3;
  localparam logic [31:0] CTRL_MASK = 32'h0000_000F;

  // Protection codes
  localparam logic [1:0] PROTECTION_CODE_00 = 2'h0;
  localparam logic [1:0] PROTECTION_CODE_01 = 2'h1;
  localparam logic [1:0] PROTECTION_CODE_10 = 2'h2;
  localparam logic [1:0] PROTECTION_CODE_11 = 2'h3;

  // ****************************************************************
  // Outcome codes and carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    FLT_NONE          = 4'h0,
    FLT_FETCH_UNMAP   = 4'h1,
    FLT_FETCH_PERM    = 4'h2,
    FLT_ILLEGAL       = 4'h3,
    FLT_MISALIGNED    = 4'h4,
    FLT_DATA_UNMAP    = 4'h5,
    FLT_DATA_PERM     = 4'h6,
    FLT_BUS_ERROR     = 4'h7,
    FLT_SPEC_LOAD_ZERO_RET = 4'h8
  } rps_fault_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        user;
  } rps_fetch_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        user;
    logic        store;
    logic        spec;
    logic        misaligned;
    logic        creg;
    logic        bus_error;
  } rps_data_req_t;

  typedef struct packed {
    logic       valid;
    rps_fault_t fault;
    logic       cacheable;
    logic       spec_load_zero;
    logic       mem_req;
  } rps_result_t;

  // One decoded syllable as the decoder sees it
  typedef struct packed {
    logic       present;
    logic       stop;
    logic       valid_op;
    logic       unused_nz;
    logic       branch;
    logic       mul;
    logic       long_imm;
    logic       mem;
    logic       priv;
    logic       sync;
    logic       sbrk;
    logic       narrow_load;
    logic       wr_en;
    logic [5:0] dest;
  } rps_syl_t;

  localparam logic [5:0] ZERO_REG = 6'h00;
  localparam logic [5:0] LINK_REG = 6'h3F;

endpackage

//--- rtl/rps_region_protect.sv
// Fetch and data region protection units with APB registers and bundle checks
//
// Local design decisions: the APB register port and the register addresses.
module rps_region_protect
  import rps_pkg::*;
#(
  parameter int FETCH_REGIONS = 4,
  parameter int DATA_REGIONS  = 8,
  parameter int SYLLABLES     = 4
) (
  input  wire logic           CLK_I,
  input  wire logic           SYS_RST_I,
  input  wire logic           PSEL_I,
  input  wire logic           PENABLE_I,
  input  wire logic           PWRITE_I,
  input  wire logic [11:0]    PADDR_I,
  input  wire logic [31:0]    PWDATA_I,
  output logic      [31:0]    PRDATA_O,
  output logic                PREADY_O,
  output logic                PSLVERR_O,
  input  wire rps_fetch_req_t FETCH_REQ_I,
  output rps_result_t         FETCH_RES_O,
  input  wire rps_data_req_t  DATA_REQ_I,
  output rps_result_t         DATA_RES_O,
  input  wire logic           BUNDLE_VALID_I,
  input  wire logic           BUNDLE_ODD_WORD_I,
  input  wire logic           BUNDLE_USER_I,
  input  wire rps_syl_t [SYLLABLES-1:0] BUNDLE_SYL_I,
  output logic                ILLEGAL_BUNDLE_O
);

  // Elaboration check: the decode serves only the documented region counts
  if (FETCH_REGIONS != 4 || DATA_REGIONS != 8 || SYLLABLES < 1 || SYLLABLES > 4) begin
    $error("rps_region_protect: unsupported parameter values");
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] fbase_reg [FETCH_REGIONS];
  logic [31:0] fattr_reg [FETCH_REGIONS];
  logic [31:0] dbase_reg [DATA_REGIONS];
  logic [31:0] dattr_reg [DATA_REGIONS];
  logic [3:0]  last_fault_reg;

  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic [2:0]  idx;

  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
  assign idx       = PADDR_I[4:2];
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !rd_hit;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    if (PADDR_I == OFS_CTRL) begin
      rd_data = ctrl_reg;
    end else if (PADDR_I == OFS_STATUS) begin
      rd_data = {28'h000_0000, last_fault_reg};
    end else if (PADDR_I[11:4] == OFS_FETCH_BASE[11:4] && PADDR_I[1:0] == 2'h0) begin
      rd_data = fbase_reg[idx[1:0]];
    end else if (PADDR_I[11:4] == OFS_FETCH_ATTR[11:4] && PADDR_I[1:0] == 2'h0) begin
      rd_data = fattr_reg[idx[1:0]];
    end else if (PADDR_I[11:5] == OFS_DATA_BASE[11:5] && PADDR_I[1:0] == 2'h0) begin
      rd_data = dbase_reg[idx];
    end else if (PADDR_I[11:5] == OFS_DATA_ATTR[11:5] && PADDR_I[1:0] == 2'h0) begin
      rd_data = dattr_reg[idx];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rd_data;
    end
  end

  // Enables reset to zero so both units start disabled
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_reg <= RESET_VALUE;
    end else if (wr_en && PADDR_I == OFS_CTRL) begin
      ctrl_reg <= PWDATA_I & CTRL_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < FETCH_REGIONS; i++) begin
        fbase_reg[i] <= RESET_VALUE;
        fattr_reg[i] <= RESET_VALUE;
      end
    end else if (wr_en) begin
      if (PADDR_I[11:4] == OFS_FETCH_BASE[11:4] && PADDR_I[1:0] == 2'h0) begin
        fbase_reg[idx[1:0]] <= PWDATA_I & BASE_MASK;
      end
      if (PADDR_I[11:4] == OFS_FETCH_ATTR[11:4] && PADDR_I[1:0] == 2'h0) begin
        fattr_reg[idx[1:0]] <= PWDATA_I & FETCH_ATTR_MASK;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < DATA_REGIONS; i++) begin
        dbase_reg[i] <= RESET_VALUE;
        dattr_reg[i] <= RESET_VALUE;
      end
    end else if (wr_en) begin
      if (PADDR_I[11:5] == OFS_DATA_BASE[11:5] && PADDR_I[1:0] == 2'h0) begin
        dbase_reg[idx] <= PWDATA_I & BASE_MASK;
      end
      if (PADDR_I[11:5] == OFS_DATA_ATTR[11:5] && PADDR_I[1:0] == 2'h0) begin
        dattr_reg[idx] <= PWDATA_I & DATA_ATTR_MASK;
      end
    end
  end

  // ****************************************************************
  // Region matching
  // ****************************************************************
  function automatic logic region_hit(input logic [31:0] addr,
                                      input logic [31:0] base,
                                      input logic [31:0] attr);
    logic [4:0]  code;
    logic [31:0] mask;
    code = attr[BIT_SIZE_LO +: 5];
    mask = 32'hFFFF_FFFF;
    // Code 01011 is 4 KB; each step doubles, 11111 covers everything
    if (code >= SIZE_CODE_MIN) begin
      mask = 32'hFFFF_FFFF << (code + 5'h01);
      if (code == 5'h1F) begin
        mask = 32'h0000_0000;
      end
    end
    region_hit = attr[BIT_ENABLE] && ((addr & mask) == (base & mask));
  endfunction

  logic              f_any;
  logic [31:0]       f_attr;
  logic              d_any;
  logic [31:0]       d_attr;

  // Ascending scan so the last, highest index hit wins
  always_comb begin
    f_any  = 1'b0;
    f_attr = 32'h0000_0000;
    for (int i = 0; i < FETCH_REGIONS; i++) begin
      if (region_hit(FETCH_REQ_I.addr, fbase_reg[i], fattr_reg[i])) begin
        f_any  = 1'b1;
        f_attr = fattr_reg[i];
      end
    end
  end

  always_comb begin
    d_any  = 1'b0;
    d_attr = 32'h0000_0000;
    for (int i = 0; i < DATA_REGIONS; i++) begin
      if (region_hit(DATA_REQ_I.addr, dbase_reg[i], dattr_reg[i])) begin
        d_any  = 1'b1;
        d_attr = dattr_reg[i];
      end
    end
  end

  // ****************************************************************
  // Fetch check
  // ****************************************************************
  rps_result_t f_res;
  logic [1:0]  f_protection_code;

  always_comb begin
    f_protection_code          = f_attr[BIT_PROTECTION_CODE_LO +: 2];
    f_res           = '0;
    f_res.valid     = FETCH_REQ_I.valid;
    f_res.cacheable = 1'b1;
    f_res.mem_req   = FETCH_REQ_I.valid;
    f_res.fault     = FLT_NONE;
    if (ctrl_reg[CTRL_FETCH_EN] && FETCH_REQ_I.valid) begin
      if (!f_any) begin
        f_res.fault = FLT_FETCH_UNMAP;
      end else begin
        unique case (f_protection_code)
          PROTECTION_CODE_00: f_res.fault = FLT_NONE;
          PROTECTION_CODE_01: f_res.fault = FLT_FETCH_PERM;
          PROTECTION_CODE_10: f_res.fault = FETCH_REQ_I.user ? FLT_FETCH_PERM : FLT_NONE;
          PROTECTION_CODE_11: f_res.fault = FLT_FETCH_PERM;
        endcase
      end
      if (f_res.fault != FLT_NONE) begin
        f_res.mem_req = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Data check and speculative load rules
  // ****************************************************************
  rps_result_t d_res;
  logic        d_unmap;
  logic        d_perm;
  logic [1:0]  d_protection_code;
  logic        spec_on;

  always_comb begin
    d_protection_code  = d_attr[BIT_PROTECTION_CODE_LO +: 2];
    d_unmap = !d_any;
    d_perm  = 1'b0;
    unique case (d_protection_code)
      PROTECTION_CODE_00: d_perm = 1'b1;
      PROTECTION_CODE_01: d_perm = DATA_REQ_I.user;
      PROTECTION_CODE_10: d_perm = DATA_REQ_I.user && DATA_REQ_I.store;
      PROTECTION_CODE_11: d_perm = 1'b0;
    endcase
    // Disabled unit treats speculative loads as plain loads
    spec_on = ctrl_reg[CTRL_DATA_EN] && DATA_REQ_I.spec && !DATA_REQ_I.store;
  end

  always_comb begin
    d_res           = '0;
    d_res.valid     = DATA_REQ_I.valid;
    d_res.mem_req   = DATA_REQ_I.valid;
    d_res.fault     = FLT_NONE;
    if (DATA_REQ_I.bus_error) begin
      d_res.fault   = FLT_BUS_ERROR;
    end else if (DATA_REQ_I.creg) begin
      d_res.fault   = DATA_REQ_I.misaligned ? FLT_MISALIGNED : FLT_NONE;
    end else if (!ctrl_reg[CTRL_DATA_EN]) begin
      d_res.fault   = DATA_REQ_I.misaligned ? FLT_MISALIGNED : FLT_NONE;
    end else begin
      d_res.cacheable = d_any && d_attr[BIT_CACHEABLE];
      d_res.spec_load_zero = d_any && d_attr[BIT_SPEC_LOAD_ZERO];
      if (spec_on && d_res.spec_load_zero) begin
        d_res.fault = FLT_SPEC_LOAD_ZERO_RET;
      end else if (spec_on) begin
        if (DATA_REQ_I.misaligned) begin
          d_res.fault = ctrl_reg[CTRL_SPEC_MALIGN] ? FLT_MISALIGNED : FLT_SPEC_LOAD_ZERO_RET;
        end else if (d_unmap) begin
          d_res.fault = ctrl_reg[CTRL_SPEC_FAULT] ? FLT_DATA_UNMAP : FLT_SPEC_LOAD_ZERO_RET;
        end else if (d_perm) begin
          d_res.fault = ctrl_reg[CTRL_SPEC_FAULT] ? FLT_DATA_PERM : FLT_SPEC_LOAD_ZERO_RET;
        end
      end else if (DATA_REQ_I.misaligned) begin
        d_res.fault = FLT_MISALIGNED;
      end else if (d_unmap) begin
        d_res.fault = FLT_DATA_UNMAP;
      end else if (d_perm) begin
        d_res.fault = FLT_DATA_PERM;
      end
    end
    if (d_res.fault != FLT_NONE) begin
      d_res.mem_req = 1'b0;
    end
    if (!DATA_REQ_I.valid) begin
      d_res.fault   = FLT_NONE;
      d_res.mem_req = 1'b0;
    end
  end

  // ****************************************************************
  // Bundle legality
  // ****************************************************************
  logic ill;

  always_comb begin
    logic any_stop;
    logic [2:0] mem_cnt;
    logic [2:0] syl_cnt;
    ill      = 1'b0;
    any_stop = 1'b0;
    mem_cnt  = 3'h0;
    syl_cnt  = 3'h0;
    for (int i = 0; i < SYLLABLES; i++) begin
      if (BUNDLE_SYL_I[i].present) begin
        syl_cnt  = syl_cnt + 3'h1;
        any_stop = any_stop | BUNDLE_SYL_I[i].stop;
        if (!BUNDLE_SYL_I[i].valid_op || BUNDLE_SYL_I[i].unused_nz) begin
          ill = 1'b1;
        end
        if (BUNDLE_SYL_I[i].branch && i != 0) begin
          ill = 1'b1;
        end
        if ((BUNDLE_SYL_I[i].mul && !BUNDLE_ODD_WORD_I) ||
            (BUNDLE_SYL_I[i].long_imm && BUNDLE_ODD_WORD_I)) begin
          ill = 1'b1;
        end
        if (BUNDLE_SYL_I[i].mem) begin
          mem_cnt = mem_cnt + 3'h1;
        end
        if (BUNDLE_SYL_I[i].priv && BUNDLE_USER_I) begin
          ill = 1'b1;
        end
        if (BUNDLE_SYL_I[i].sbrk && !BUNDLE_SYL_I[i].stop) begin
          ill = 1'b1;
        end
        if ((BUNDLE_SYL_I[i].narrow_load || BUNDLE_SYL_I[i].mul) &&
            BUNDLE_SYL_I[i].wr_en && BUNDLE_SYL_I[i].dest == LINK_REG) begin
          ill = 1'b1;
        end
        for (int j = i + 1; j < SYLLABLES; j++) begin
          if (BUNDLE_SYL_I[j].present && BUNDLE_SYL_I[i].wr_en && BUNDLE_SYL_I[j].wr_en &&
              BUNDLE_SYL_I[i].dest == BUNDLE_SYL_I[j].dest &&
              BUNDLE_SYL_I[i].dest != ZERO_REG) begin
            ill = 1'b1;
          end
        end
      end
    end
    if (!any_stop || mem_cnt > 3'h1) begin
      ill = 1'b1;
    end
    for (int i = 0; i < SYLLABLES; i++) begin
      if (BUNDLE_SYL_I[i].present && BUNDLE_SYL_I[i].sync && syl_cnt > 3'h1) begin
        ill = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registered results, one stage after the request
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      FETCH_RES_O      <= '0;
      DATA_RES_O       <= '0;
      ILLEGAL_BUNDLE_O <= 1'b0;
    end else begin
      FETCH_RES_O      <= f_res;
      DATA_RES_O       <= d_res;
      ILLEGAL_BUNDLE_O <= BUNDLE_VALID_I && ill;
    end
  end

  // Last non-pass data or fetch outcome stays visible to software; data wins when both fault in one cycle
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      last_fault_reg <= 4'h0;
    end else if (d_res.valid && d_res.fault != FLT_NONE) begin
      last_fault_reg <= d_res.fault;
    end else if (f_res.valid && f_res.fault != FLT_NONE) begin
      last_fault_reg <= f_res.fault;
    end
  end

endmodule

//--- verif/rps_region_protect_properties.sv
// Checker of the region protection block ports
module rps_chk
  import rps_pkg::*;
#(
  parameter int SYLLABLES = 4
) (
  input wire logic           CLK_I,
  input wire logic           SYS_RST_I,
  input wire logic           PSEL_I,
  input wire logic           PENABLE_I,
  input wire logic           PWRITE_I,
  input wire logic [11:0]    PADDR_I,
  input wire logic [31:0]    PWDATA_I,
  input wire logic [31:0]    PRDATA_O,
  input wire logic           PREADY_O,
  input wire logic           PSLVERR_O,
  input wire rps_fetch_req_t FETCH_REQ_I,
  input wire rps_result_t    FETCH_RES_O,
  input wire rps_data_req_t  DATA_REQ_I,
  input wire rps_result_t    DATA_RES_O,
  input wire logic           BUNDLE_VALID_I,
  input wire logic           BUNDLE_ODD_WORD_I,
  input wire logic           BUNDLE_USER_I,
  input wire rps_syl_t [SYLLABLES-1:0] BUNDLE_SYL_I,
  input wire logic           ILLEGAL_BUNDLE_O
);
  logic [1:0] en_reg;
  logic       no_stop;
  // Shadow of the unit enables, taken from control writes
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      en_reg <= 2'h0;
    end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_CTRL) begin
      en_reg <= PWDATA_I[1:0];
    end
  end
  always_comb begin
    no_stop = 1'b1;
    for (int i = 0; i < SYLLABLES; i++) begin
      if (BUNDLE_SYL_I[i].present && BUNDLE_SYL_I[i].stop) begin
        no_stop = 1'b0;
      end
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  property p_fetch_stage; FETCH_RES_O.valid == $past(FETCH_REQ_I.valid); endproperty
  a_fetch_stage: assert property (p_fetch_stage) else $error("fetch result late");
  property p_data_stage; DATA_RES_O.valid == $past(DATA_REQ_I.valid); endproperty
  a_data_stage: assert property (p_data_stage) else $error("data result late");
  property p_bus_err;
    DATA_REQ_I.valid && DATA_REQ_I.bus_error |=> DATA_RES_O.fault == FLT_BUS_ERROR;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error lost");
  property p_misalign;
    DATA_REQ_I.valid && DATA_REQ_I.misaligned && !DATA_REQ_I.spec && !DATA_REQ_I.bus_error
    |=> DATA_RES_O.fault == FLT_MISALIGNED;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned not faulted");
  property p_creg;
    DATA_REQ_I.valid && DATA_REQ_I.creg && !DATA_REQ_I.misaligned && !DATA_REQ_I.bus_error
    |=> DATA_RES_O.fault == FLT_NONE;
  endproperty
  a_creg: assert property (p_creg) else $error("control access checked");
  property p_data_off;
    DATA_REQ_I.valid && !en_reg[1] && !DATA_REQ_I.misaligned && !DATA_REQ_I.bus_error
    |=> DATA_RES_O.fault == FLT_NONE && !DATA_RES_O.cacheable;
  endproperty
  a_data_off: assert property (p_data_off) else $error("disabled data unit acted");
  property p_fetch_off;
    FETCH_REQ_I.valid && !en_reg[0]
    |=> FETCH_RES_O.fault == FLT_NONE && FETCH_RES_O.cacheable && FETCH_RES_O.mem_req;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("disabled fetch unit acted");
  property p_no_mem; DATA_RES_O.fault != FLT_NONE |-> !DATA_RES_O.mem_req; endproperty
  a_no_mem: assert property (p_no_mem) else $error("memory request on fault");
  property p_no_stop; BUNDLE_VALID_I && no_stop |=> ILLEGAL_BUNDLE_O; endproperty
  a_no_stop: assert property (p_no_stop) else $error("missing stop bit passed");
  c_zero: cover property (DATA_RES_O.fault == FLT_SPEC_LOAD_ZERO_RET);
  c_perm: cover property (FETCH_RES_O.fault == FLT_FETCH_PERM);
  c_ill: cover property (ILLEGAL_BUNDLE_O);
endmodule

bind rps_region_protect rps_chk #(.SYLLABLES(SYLLABLES)) i_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .FETCH_REQ_I(FETCH_REQ_I),
  .FETCH_RES_O(FETCH_RES_O), .DATA_REQ_I(DATA_REQ_I), .DATA_RES_O(DATA_RES_O),
  .BUNDLE_VALID_I(BUNDLE_VALID_I), .BUNDLE_ODD_WORD_I(BUNDLE_ODD_WORD_I),
  .BUNDLE_USER_I(BUNDLE_USER_I), .BUNDLE_SYL_I(BUNDLE_SYL_I),
  .ILLEGAL_BUNDLE_O(ILLEGAL_BUNDLE_O));

//--- verif/rps_core_model.sv
// Core pipeline model that issues fetch, data and bundle checks
module rps_core_model
  import rps_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire rps_result_t FETCH_RES_I,
  input  wire rps_result_t DATA_RES_I,
  input  wire logic        ILLEGAL_I,
  output rps_fetch_req_t   FETCH_REQ_O = '0,
  output rps_data_req_t    DATA_REQ_O = '0,
  output logic             BUNDLE_VALID_O = 1'b0,
  output logic             BUNDLE_ODD_O = 1'b0,
  output logic             BUNDLE_USER_O = 1'b0,
  output rps_syl_t [3:0]   BUNDLE_SYL_O = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released fields show inverted values, except the bundle odd and user flags, so stale data is never trusted
  task automatic fetch(input logic [31:0] a, input logic u, output rps_result_t r);
    @(posedge CLK_I);
    FETCH_REQ_O <= {1'b1, a, u};
    @(posedge CLK_I);
    FETCH_REQ_O <= {1'b0, ~a, ~u};
    @(negedge CLK_I);
    r = FETCH_RES_I;
  endtask
  task automatic load(input rps_data_req_t q, output rps_result_t r);
    @(posedge CLK_I);
    DATA_REQ_O <= q;
    @(posedge CLK_I);
    DATA_REQ_O <= {1'b0, ~q[37:0]};
    @(negedge CLK_I);
    r = DATA_RES_I;
  endtask
  task automatic bundle(input rps_syl_t [3:0] s, input logic odd, input logic u, output logic x);
    @(posedge CLK_I);
    BUNDLE_VALID_O <= 1'b1;
    BUNDLE_SYL_O <= s;
    BUNDLE_ODD_O <= odd;
    BUNDLE_USER_O <= u;
    @(posedge CLK_I);
    BUNDLE_VALID_O <= 1'b0;
    BUNDLE_SYL_O <= ~s;
    @(negedge CLK_I);
    x = ILLEGAL_I;
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench of the region protection block
module tb
  import rps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] sa = 19'h70041, sb = 19'h50042, stp = 19'h20000, vld = 19'h10000;
  localparam logic [18:0] unu = 19'h08000, br = 19'h04000, mul = 19'h02000, lim = 19'h01000;
  localparam logic [18:0] mem = 19'h00800, prv = 19'h00400, syn = 19'h00200, sbk = 19'h00100;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q_s;
  logic pready, pslverr, illegal, b_valid, b_odd, b_user, e_s, x_s;
  rps_fetch_req_t f_req;
  rps_data_req_t d_req;
  rps_result_t f_res, d_res, r_s;
  rps_syl_t [3:0] syl;
  int bad_count = 0, checks = 0;
  always #10 clk = ~clk;
  rps_region_protect i_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FETCH_REQ_I(f_req), .FETCH_RES_O(f_res), .DATA_REQ_I(d_req),
    .DATA_RES_O(d_res), .BUNDLE_VALID_I(b_valid), .BUNDLE_ODD_WORD_I(b_odd),
    .BUNDLE_USER_I(b_user), .BUNDLE_SYL_I(syl), .ILLEGAL_BUNDLE_O(illegal));
  rps_core_model i_core (
    .CLK_I(clk), .FETCH_RES_I(f_res), .DATA_RES_I(d_res), .ILLEGAL_I(illegal),
    .FETCH_REQ_O(f_req), .DATA_REQ_O(d_req), .BUNDLE_VALID_O(b_valid),
    .BUNDLE_ODD_O(b_odd), .BUNDLE_USER_O(b_user), .BUNDLE_SYL_O(syl));
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    checks++;
    if (got !== x) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t no ready", $time);
      stop_test();
    end
    q_s = prdata;
    e_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q_s, x);
  endtask
  task automatic dchk(input logic [31:0] a, input logic [5:0] f, input rps_fault_t x);
    i_core.load({1'b1, a, f}, r_s);
    chk(32'(r_s.fault), 32'(x));
  endtask
  task automatic fchk(input logic [31:0] a, input logic u, input rps_fault_t x);
    i_core.fetch(a, u, r_s);
    chk(32'(r_s.fault), 32'(x));
  endtask
  task automatic bun(input logic [18:0] s0, s1, input logic odd, u, x);
    i_core.bundle({19'h0, 19'h0, s1, s0}, odd, u, x_s);
    chk(32'(x_s), 32'(x));
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_DATA_BASE + 12'h01C, 32'h0);
    rd(OFS_DATA_ATTR + 12'h01C, 32'h0);
    rd(OFS_FETCH_ATTR + 12'h00C, 32'h0);
    apb(1'b1, OFS_DATA_BASE + 12'h004, 32'hFFFF_FFFF);
    rd(OFS_DATA_BASE + 12'h004, BASE_MASK);
    apb(1'b1, OFS_DATA_ATTR + 12'h004, 32'hFFFF_FFFF);
    rd(OFS_DATA_ATTR + 12'h004, DATA_ATTR_MASK);
    apb(1'b1, OFS_FETCH_ATTR + 12'h00C, 32'hFFFF_FFFF);
    rd(OFS_FETCH_ATTR + 12'h00C, FETCH_ATTR_MASK);
    rd(12'hFFC, 32'h0);
    chk(32'(e_s), 32'h1);
    fchk(32'h0000_1000, 1'b1, FLT_NONE);
    chk(32'(r_s.cacheable), 32'h1);
    dchk(32'h0000_1000, 6'h28, FLT_NONE);
    chk(32'(r_s.cacheable), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_DATA_ATTR + 12'h004, 32'h0);
    dchk(32'h0000_1000, 6'h00, FLT_DATA_UNMAP);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFS_FETCH_ATTR + 12'h00C, {15'h0, 5'h1F, 9'h0, p[1:0], 1'b1});
      fchk(32'h8000_0000, 1'b0, p[0] ? FLT_FETCH_PERM : FLT_NONE);
      fchk(32'h8000_0000, 1'b1, p == 0 ? FLT_NONE : FLT_FETCH_PERM);
    end
    apb(1'b1, OFS_FETCH_ATTR + 12'h00C, 32'h0001_F000);
    fchk(32'h8000_0000, 1'b0, FLT_FETCH_UNMAP);
    apb(1'b1, OFS_DATA_BASE, 32'h0);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFS_DATA_ATTR, {15'h0, 5'h1F, 9'h010, p[1:0], 1'b1});
      for (int k = 0; k < 4; k++) begin
        dchk(32'h4000_0000, {k[1:0], 4'h0}, (p == 3 || (p == 2 && k != 3) || (p == 1 && k < 2))
             ? FLT_NONE : FLT_DATA_PERM);
      end
    end
    apb(1'b1, OFS_DATA_BASE + 12'h01C, 32'h1000_0000);
    apb(1'b1, OFS_DATA_ATTR + 12'h01C, 32'h0000_B001);
    dchk(32'h1000_0FFC, 6'h00, FLT_DATA_PERM);
    dchk(32'h1000_1000, 6'h00, FLT_NONE);
    chk(32'(r_s.cacheable), 32'h1);
    apb(1'b1, OFS_DATA_ATTR + 12'h01C, 32'h0000_C001);
    dchk(32'h1000_1FFC, 6'h00, FLT_DATA_PERM);
    apb(1'b1, OFS_DATA_ATTR + 12'h01C, 32'h0000_C000);
    dchk(32'h1000_0000, 6'h00, FLT_NONE);
    apb(1'b1, OFS_DATA_ATTR, 32'h0000_B003);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_CTRL, {28'h0, c[1:0], 2'h3});
      dchk(32'h0000_0100, 6'h28, c[0] ? FLT_DATA_PERM : FLT_SPEC_LOAD_ZERO_RET);
      dchk(32'h8000_0000, 6'h08, c[0] ? FLT_DATA_UNMAP : FLT_SPEC_LOAD_ZERO_RET);
      dchk(32'h8000_0000, 6'h0C, c[1] ? FLT_MISALIGNED : FLT_SPEC_LOAD_ZERO_RET);
    end
    apb(1'b1, OFS_DATA_BASE + 12'h018, 32'h2000_0000);
    apb(1'b1, OFS_DATA_ATTR + 12'h018, 32'h0000_B101);
    dchk(32'h2000_0000, 6'h08, FLT_SPEC_LOAD_ZERO_RET);
    chk(32'(r_s.mem_req), 32'h0);
    chk(32'(r_s.spec_load_zero), 32'h1);
    dchk(32'h2000_0000, 6'h00, FLT_DATA_PERM);
    dchk(32'h0000_0100, 6'h08, FLT_NONE);
    chk(32'(r_s.mem_req), 32'h1);
    dchk(32'h0000_0100, 6'h04, FLT_MISALIGNED);
    dchk(32'h0000_0100, 6'h09, FLT_BUS_ERROR);
    dchk(32'h8000_0000, 6'h22, FLT_NONE);
    rd(OFS_STATUS, 32'(FLT_BUS_ERROR));
    bun(sb, sa, 1'b0, 1'b0, 1'b0);
    bun(sb, sa ^ stp, 1'b0, 1'b0, 1'b1);
    bun(sa ^ vld, 19'h0, 1'b0, 1'b0, 1'b1);
    bun(sa | unu, 19'h0, 1'b0, 1'b0, 1'b1);
    bun(sb, sa | br, 1'b0, 1'b0, 1'b1);
    bun(sa | mul, 19'h0, 1'b0, 1'b0, 1'b1);
    bun(sa | mul, 19'h0, 1'b1, 1'b0, 1'b0);
    bun(sa | lim, 19'h0, 1'b1, 1'b0, 1'b1);
    bun(sb | mem, sa | mem, 1'b0, 1'b0, 1'b1);
    bun(sa | prv, 19'h0, 1'b0, 1'b1, 1'b1);
    bun(sa | prv, 19'h0, 1'b0, 1'b0, 1'b0);
    bun(sb ^ 19'h3, sa, 1'b0, 1'b0, 1'b1);
    bun(sb & ~19'h3F, sa & ~19'h3F, 1'b0, 1'b0, 1'b0);
    bun(sa | mul | 19'h3E, 19'h0, 1'b1, 1'b0, 1'b1);
    bun(sb, sa | syn, 1'b0, 1'b0, 1'b1);
    bun(sb | sbk, sa, 1'b0, 1'b0, 1'b1);
    stop_test();
  end
endmodule
